// ### hdl/urx_pkg.sv
// Package for the UART receive error and interrupt block.
// Assumes a single 250 MHz system clock and byte addresses on the register bus.
`default_nettype none

package urx_pkg;

  // Register byte offsets
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_DATA   = 4'h4;
  localparam logic [3:0] ADDR_CTRL   = 4'h8;
  localparam logic [3:0] ADDR_BAUD   = 4'hC;

  // uart_status_reg bit positions
  localparam int ST_OVERRUN  = 0;
  localparam int ST_NOISE    = 1;
  localparam int ST_FRAMING  = 2;
  localparam int ST_PARITY   = 3;
  localparam int ST_RX_AVAIL = 4;
  localparam int ST_RX_IDLE  = 5;
  localparam int ST_TX_EMPTY = 6;
  localparam int ST_TX_IDLE  = 7;
  localparam int ST_W        = 8;

  // uart_control_2 bit positions
  localparam int CT_NINE_BIT    = 0;
  localparam int CT_PARITY_EN   = 1;
  localparam int CT_PARITY_ODD  = 2;
  localparam int CT_TWO_STOP    = 3;
  localparam int CT_RX_EN       = 4;
  localparam int CT_ADDR_DET    = 5;
  localparam int CT_WAKE        = 6;
  localparam int CT_RX_INT      = 7;
  localparam int CT_TX_EMPTY_IE = 8;
  localparam int CT_TX_IDLE_IE  = 9;
  localparam int CT_UART_INT    = 10;
  localparam int CT_GLOBAL_INT  = 11;
  localparam int CTRL_W         = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;

  // Oversampling divider and sample points
  localparam int BAUD_W = 16;
  localparam logic [BAUD_W-1:0] BAUD_RESET   = 16'h0001;
  localparam logic [3:0]        SAMPLE_FIRST = 4'h7;
  localparam logic [3:0]        SAMPLE_MID   = 4'h8;
  localparam logic [3:0]        SAMPLE_LAST  = 4'h9;
  localparam logic [3:0]        LAST_BIT_8   = 4'h7;
  localparam logic [3:0]        LAST_BIT_9   = 4'h8;

  // Word and entry layout
  localparam int WORD_W   = 9;
  localparam int ENT_FRAMING_ERROR_FLAG = 9;
  localparam int ENT_PARITY_ERROR_FLAG = 10;
  localparam int ENT_W    = 11;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b011,
    RX_PARITY = 3'b010,
    RX_STOP1  = 3'b110,
    RX_STOP2  = 3'b111
  } urx_state_t;

endpackage

`default_nettype wire

// ### hdl/urx_core.sv
// UART receiver with two-word buffer, error flags and combined interrupt request.
// Assumes rx_pin and transmitter status inputs are synchronous to clk_sys.
//
// Function
// - Buffer holds two whole words while a third shifts in.
// - Third word into full buffer sets overrun, buffer kept, shift word lost.
// - Overrun requests interrupt when rx_int_enable set.
// - Overrun clears only after status access then data read.
// - Noisy frame still stored; noise flag rises with data available.
// - Noise has no interrupt of its own.
// - Noise clears after status access then data read.
// - Low stop bit sets framing error; two stops must both be high.
// - Framing and parity stored with word; reset clears them.
// - Parity error only when parity enabled, odd or even as chosen.
// - Interrupt request is an active-low pulse.
// - Six sources: tx empty, tx idle, rx data, overrun, address, wake.
// - Tx sources have own enables; rx data and overrun share one.
// - Address detect requests interrupt without flag when enabled.
// - Clock off, wake and rx int enabled: falling rx edge interrupts.
// - Status flags read-only; overrun and noise clear only by access sequence; framing, parity, data available follow the buffer, the rest their sources.
// - Request masked unless global and UART interrupt enables set.
// - Address mode: rx data interrupt only if top word bit high.
// - Address mode off: every new word requests interrupt.
// - Data available set while buffer holds an unread word.
// - Data available clears when a data read takes the last word; no status access needed.
// - Nine-bit select gives nine-bit words, else eight.
`default_nettype none

module urx_core #(
  parameter int RX_DEPTH = 2
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // Serial line and transmitter status
  input  wire logic        rx_pin,
  input  wire logic        tx_empty,
  input  wire logic        tx_idle,
  input  wire logic        uart_clock_off,
  // Interrupt request
  output var  logic        uart_irq_n
);

  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CNT_W = $clog2(RX_DEPTH + 1);

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  logic [urx_pkg::CTRL_W-1:0] uart_control_2;
  logic [urx_pkg::BAUD_W-1:0] baud_div;
  logic [urx_pkg::BAUD_W-1:0] baud_cnt;
  logic                       tick;
  urx_pkg::urx_state_t        state;
  logic [3:0]                 os_cnt;
  logic [3:0]                 bit_idx;
  logic [urx_pkg::WORD_W-1:0] shreg;
  logic                       s_a;
  logic                       s_b;
  logic                       noise_acc;
  logic                       stop1_ok;
  logic                       par_bit;
  logic [urx_pkg::ENT_W-1:0]  rx_data_fifo [RX_DEPTH];
  logic [PTR_W-1:0]           wr_ptr;
  logic [PTR_W-1:0]           rd_ptr;
  logic [CNT_W-1:0]           count;
  logic                       overrun_flag;
  logic                       noise_flag;
  logic                       armed;
  logic                       rx_prev;
  logic                       tx_empty_q;
  logic                       tx_idle_q;

  // Control decode
  logic nine_bit, pen, podd, two_stop, rx_en;
  assign nine_bit = uart_control_2[urx_pkg::CT_NINE_BIT];
  assign pen      = uart_control_2[urx_pkg::CT_PARITY_EN];
  assign podd     = uart_control_2[urx_pkg::CT_PARITY_ODD];
  assign two_stop = uart_control_2[urx_pkg::CT_TWO_STOP];
  assign rx_en    = uart_control_2[urx_pkg::CT_RX_EN];

  // Bus handshake terms
  logic acc, rd_acc, wr_acc, st_acc, data_rd, clear_seq;
  assign acc       = (avs_read | avs_write) & avs_waitrequest;
  assign rd_acc    = avs_read & avs_waitrequest;
  assign wr_acc    = avs_write & avs_waitrequest & ~avs_read;
  assign st_acc    = acc && (avs_address == urx_pkg::ADDR_STATUS);
  assign data_rd   = rd_acc && (avs_address == urx_pkg::ADDR_DATA);
  assign clear_seq = data_rd & armed;

  // Bit decision and frame completion
  logic decide, vote, bit_noise, frame_done, done_framing_error_flag, done_parity_error_flag, done_noise, top_bit;
  logic full, push, pop;
  assign decide    = tick && (state != urx_pkg::RX_IDLE) && (os_cnt == urx_pkg::SAMPLE_LAST);
  assign vote      = maj3(s_a, s_b, rx_pin);
  assign bit_noise = ~((s_a == s_b) && (s_b == rx_pin));
  assign frame_done = decide && ((state == urx_pkg::RX_STOP2) ||
                                 ((state == urx_pkg::RX_STOP1) && !two_stop));
  assign done_framing_error_flag  = (state == urx_pkg::RX_STOP2) ? (!stop1_ok || !vote) : !vote;
  assign done_parity_error_flag  = pen && ((^shreg ^ par_bit) != podd);
  assign done_noise = noise_acc | bit_noise;
  assign top_bit    = nine_bit ? shreg[8] : shreg[7];

  // Index of the last data bit for the chosen word length
  logic [3:0] last_idx;
  assign last_idx   = nine_bit ? urx_pkg::LAST_BIT_9 : urx_pkg::LAST_BIT_8;
  assign full       = (count == CNT_W'(RX_DEPTH));
  assign push       = frame_done && !full;
  assign pop        = data_rd && (count != '0);

  // Oversampling tick, halted while the UART clock is off
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      baud_cnt <= '0;
      tick     <= 1'b0;
    end else if (uart_clock_off || !rx_en) begin
      baud_cnt <= '0;
      tick     <= 1'b0;
    end else if (baud_cnt >= baud_div) begin
      baud_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // Receive shifter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state     <= urx_pkg::RX_IDLE;
      os_cnt    <= '0;
      bit_idx   <= '0;
      shreg     <= '0;
      s_a       <= 1'b1;
      s_b       <= 1'b1;
      noise_acc <= 1'b0;
      stop1_ok  <= 1'b1;
      par_bit   <= 1'b0;
    end else if (tick) begin
      if (state == urx_pkg::RX_IDLE) begin
        if (!rx_pin) begin
          state     <= urx_pkg::RX_START;
          os_cnt    <= '0;
          bit_idx   <= '0;
          shreg     <= '0;
          noise_acc <= 1'b0;
        end
      end else begin
        os_cnt <= os_cnt + 1'b1;
        if (os_cnt == urx_pkg::SAMPLE_FIRST) s_a <= rx_pin;
        if (os_cnt == urx_pkg::SAMPLE_MID) s_b <= rx_pin;
        if (os_cnt == urx_pkg::SAMPLE_LAST) begin
          noise_acc <= noise_acc | bit_noise;
          case (state)
            urx_pkg::RX_START: begin
              // A start bit that votes high was a glitch: back to idle
              state <= vote ? urx_pkg::RX_IDLE : urx_pkg::RX_DATA;
            end
            urx_pkg::RX_DATA: begin
              shreg[bit_idx] <= vote;
              bit_idx        <= bit_idx + 1'b1;
              if (bit_idx == last_idx) begin
                state <= pen ? urx_pkg::RX_PARITY : urx_pkg::RX_STOP1;
              end
            end
            urx_pkg::RX_PARITY: begin
              par_bit <= vote;
              state   <= urx_pkg::RX_STOP1;
            end
            urx_pkg::RX_STOP1: begin
              stop1_ok <= vote;
              state    <= two_stop ? urx_pkg::RX_STOP2 : urx_pkg::RX_IDLE;
            end
            default: state <= urx_pkg::RX_IDLE;
          endcase
        end
      end
    end
  end

  // Two-entry buffer; each entry carries its own framing and parity status
  always_ff @(posedge clk_sys) begin
    if (push) begin
      rx_data_fifo[wr_ptr] <= {done_parity_error_flag, done_framing_error_flag, shreg};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= PTR_W'(wr_ptr + 1'b1);
      if (pop) rd_ptr <= PTR_W'(rd_ptr + 1'b1);
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      overrun_flag <= 1'b0;
      noise_flag   <= 1'b0;
      armed        <= 1'b0;
    end else begin
      if (frame_done && full) overrun_flag <= 1'b1;
      else if (clear_seq) overrun_flag <= 1'b0;
      if (push && done_noise) noise_flag <= 1'b1;
      else if (clear_seq) noise_flag <= 1'b0;
      if (st_acc) armed <= 1'b1;
      else if (data_rd) armed <= 1'b0;
    end
  end

  // Status image; head entry supplies the error bits of the word to be read
  logic [urx_pkg::ST_W-1:0]  status_word;
  logic [urx_pkg::ENT_W-1:0] head;
  assign head = (count != '0) ? rx_data_fifo[rd_ptr] : '0;
  always_comb begin
    status_word                       = '0;
    status_word[urx_pkg::ST_OVERRUN]  = overrun_flag;
    status_word[urx_pkg::ST_NOISE]    = noise_flag;
    status_word[urx_pkg::ST_FRAMING]  = head[urx_pkg::ENT_FRAMING_ERROR_FLAG];
    status_word[urx_pkg::ST_PARITY]   = head[urx_pkg::ENT_PARITY_ERROR_FLAG];
    status_word[urx_pkg::ST_RX_AVAIL] = (count != '0);
    status_word[urx_pkg::ST_RX_IDLE]  = (state == urx_pkg::RX_IDLE);
    status_word[urx_pkg::ST_TX_EMPTY] = tx_empty;
    status_word[urx_pkg::ST_TX_IDLE]  = tx_idle;
  end

  // Avalon slave: one wait cycle, then the answer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) avs_waitrequest <= 1'b1;
    else avs_waitrequest <= !acc;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (rd_acc) begin
      case (avs_address)
        urx_pkg::ADDR_STATUS: avs_readdata <= 32'(status_word);
        urx_pkg::ADDR_DATA:   avs_readdata <= 32'(head[urx_pkg::WORD_W-1:0]);
        urx_pkg::ADDR_CTRL:   avs_readdata <= 32'(uart_control_2);
        urx_pkg::ADDR_BAUD:   avs_readdata <= 32'(baud_div);
        default:              avs_readdata <= '0;
      endcase
    end
  end

  // Status and data are not writable from the bus
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      uart_control_2 <= urx_pkg::CTRL_RESET;
      baud_div       <= urx_pkg::BAUD_RESET;
    end else if (wr_acc) begin
      if (avs_address == urx_pkg::ADDR_CTRL)
        uart_control_2 <= avs_writedata[urx_pkg::CTRL_W-1:0];
      if (avs_address == urx_pkg::ADDR_BAUD)
        baud_div <= avs_writedata[urx_pkg::BAUD_W-1:0];
    end
  end

  // Interrupt sources
  logic ev_rx, ev_ovr, ev_addr, ev_txe, ev_txi, ev_wake, ev_any, irq_gate;
  assign ev_rx   = push && uart_control_2[urx_pkg::CT_RX_INT] &&
                   (!uart_control_2[urx_pkg::CT_ADDR_DET] || top_bit);
  assign ev_ovr  = frame_done && full && uart_control_2[urx_pkg::CT_RX_INT];
  assign ev_addr = push && uart_control_2[urx_pkg::CT_ADDR_DET] && top_bit;
  assign ev_txe  = tx_empty && !tx_empty_q && uart_control_2[urx_pkg::CT_TX_EMPTY_IE];
  assign ev_txi  = tx_idle && !tx_idle_q && uart_control_2[urx_pkg::CT_TX_IDLE_IE];
  assign ev_wake = uart_clock_off && uart_control_2[urx_pkg::CT_WAKE] &&
                   uart_control_2[urx_pkg::CT_RX_INT] && rx_prev && !rx_pin;
  // Noise is deliberately absent: it rides on the rx data event
  assign ev_any  = ev_rx | ev_ovr | ev_addr | ev_txe | ev_txi | ev_wake;
  assign irq_gate = uart_control_2[urx_pkg::CT_GLOBAL_INT] &&
                    uart_control_2[urx_pkg::CT_UART_INT];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_prev    <= 1'b1;
      tx_empty_q <= 1'b0;
      tx_idle_q  <= 1'b0;
      uart_irq_n <= 1'b1;
    end else begin
      rx_prev    <= rx_pin;
      tx_empty_q <= tx_empty;
      tx_idle_q  <= tx_idle;
      uart_irq_n <= !(ev_any && irq_gate);
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  buffer_fill_a: assert property (
    (frame_done && count == CNT_W'(1) && !pop) |=> (count == CNT_W'(2)))
    else $error("second word not held in buffer");

  overrun_keep_a: assert property (
    (frame_done && full && !pop) |=>
      (overrun_flag && full && rx_data_fifo[rd_ptr] == $past(rx_data_fifo[rd_ptr])))
    else $error("overrun disturbed buffered word");

  overrun_irq_a: assert property (
    (frame_done && full && uart_control_2[urx_pkg::CT_RX_INT] && irq_gate) |=> !uart_irq_n)
    else $error("overrun gave no interrupt");

  overrun_hold_a: assert property (
    (overrun_flag && !clear_seq) |=> overrun_flag [*1])
    else $error("overrun cleared without sequence");

  noise_set_a: assert property (
    (push && done_noise) |=> (noise_flag && count != '0))
    else $error("noise flag not set with word");

  noise_rise_a: assert property (
    $rose(noise_flag) |-> $past(push))
    else $error("noise flag rose without a word");

  framing_stop_a: assert property (
    (frame_done && !vote && count == '0) |=> head[urx_pkg::ENT_FRAMING_ERROR_FLAG])
    else $error("low stop bit not flagged");

  parity_off_a: assert property (
    (push && !pen) |=> !rx_data_fifo[$past(wr_ptr)][urx_pkg::ENT_PARITY_ERROR_FLAG])
    else $error("parity error with parity off");

  irq_mask_a: assert property (
    !uart_irq_n |-> $past(irq_gate))
    else $error("interrupt passed while masked");

  addr_qual_a: assert property (
    (push && uart_control_2[urx_pkg::CT_ADDR_DET] && !top_bit) |-> !ev_rx && !ev_addr)
    else $error("data word raised address-mode interrupt");

  avail_clear_a: assert property (
    (pop && count == CNT_W'(1) && !push) |=> (count == '0) && !status_word[urx_pkg::ST_RX_AVAIL])
    else $error("data available stuck after last read");

  bus_answer_a: assert property (
    acc |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after accept");

  wake_irq_a: assert property (
    (ev_wake && irq_gate) |=> !uart_irq_n)
    else $error("wake edge gave no interrupt");

  avail_set_a: assert property (
    (count != '0) |-> status_word[urx_pkg::ST_RX_AVAIL])
    else $error("data available low with word held");

  every_word_a: assert property (
    (push && uart_control_2[urx_pkg::CT_RX_INT] && !uart_control_2[urx_pkg::CT_ADDR_DET]) |-> ev_rx)
    else $error("stored word gave no rx data event");

  overrun_seen_c: cover property (frame_done && full);
  noise_word_c:   cover property (push && done_noise);
  wake_irq_c:     cover property (ev_wake && irq_gate ##1 !uart_irq_n);
  clear_seq_c:    cover property (st_acc ##[1:20] clear_seq);

endmodule

`default_nettype wire

// ### testbench/urx_line_model.sv
// Far-end serial transmitter that drives the receive line of the block.
// Assumes the receiver runs with divisor 1 (tick every second cycle), so one bit
// lasts 32 clk_sys cycles.
`default_nettype none

module urx_line_model (
  // Clock
  input  wire logic clk_sys,
  // Serial line
  output var  logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BIT_CYC = 32;

  // Line idles high between frames
  initial rx_pin = 1'b1;

  // A three-cycle glitch covers the first vote sample whatever the tick phase,
  // but not the other two, so the vote still wins while the samples disagree
  task automatic put_bit(input logic b, input logic glitch);
    for (int i = 0; i < BIT_CYC; i++) begin
      @(posedge clk_sys);
      rx_pin <= (glitch && i >= 15 && i <= 17) ? ~b : b;
    end
  endtask

  // Flags: nine, parity on, odd, bad parity, two stops, bad stop, noise
  task automatic send(input logic [8:0] w, input logic [6:0] f);
    logic par;
    par = ^w[7:0] ^ (f[6] & w[8]) ^ f[4] ^ f[3];
    put_bit(1'b0, 1'b0);
    for (int i = 0; i < 9; i++)
      if (i < 8 || f[6]) put_bit(w[i], f[0] && i == 0);
    if (f[5]) put_bit(par, 1'b0);
    if (f[2]) put_bit(1'b1, 1'b0);
    put_bit(~f[1], 1'b0);
    put_bit(1'b1, 1'b0);
  endtask

  // Falling edge followed by a return to idle, for the wake watch
  task automatic wake_edge();
    put_bit(1'b0, 1'b0);
    put_bit(1'b1, 1'b0);
  endtask

endmodule

`default_nettype wire

// ### testbench/tb_uart_rx_error_interrupt.sv
// Self-checking bench for the UART receive error and interrupt block.
// Assumes urx_core with the map of urx_pkg and the line model as far end.
`default_nettype none

module tb_uart_rx_error_interrupt;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] F_NINE = 7'h40;
  localparam logic [6:0] F_PAR  = 7'h20;
  localparam logic [6:0] F_ODD  = 7'h10;
  localparam logic [6:0] F_BADP = 7'h08;
  localparam logic [6:0] F_TWO  = 7'h04;
  localparam logic [6:0] F_BADS = 7'h02;
  localparam logic [6:0] F_NZ   = 7'h01;

  logic        clk_sys;
  logic        rst_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_pin;
  logic        tx_empty;
  logic        tx_idle;
  logic        uart_clock_off;
  logic        uart_irq_n;
  logic [31:0] rd;
  logic [31:0] base;
  logic [31:0] idl;
  logic [31:0] av;
  int          err_total;
  int          n_tests;
  int          irq_cnt;
  int          irq_base;
  int          cyc;

  urx_core #(.RX_DEPTH(2)) urx_core_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .tx_empty(tx_empty),
    .tx_idle(tx_idle), .uart_clock_off(uart_clock_off), .uart_irq_n(uart_irq_n));

  urx_line_model urx_line_model_inst (.clk_sys(clk_sys), .rx_pin(rx_pin));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] bv(input int b);
    return 32'h1 << b;
  endfunction

  task automatic close_out();
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Counts low cycles of the request; also cuts a hang short
  always @(posedge clk_sys) begin
    if (uart_irq_n === 1'b0) irq_cnt <= irq_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      $display("Error timeout expected 0 seen %0d", cyc);
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic irq_chk(input int exp);
    repeat (4) @(posedge clk_sys);
    n_tests++;
    if (irq_cnt - irq_base != exp) begin
      err_total++;
      $display("Error irq pulses expected %0d seen %0d", exp, irq_cnt - irq_base);
    end
    irq_base = irq_cnt;
  endtask

  // One Avalon transfer; the request stands until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rc(input string name, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task automatic tx(input logic [8:0] w, input logic [6:0] f);
    urx_line_model_inst.send(w, f);
  endtask

  initial begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    tx_empty = 1'b0;
    tx_idle = 1'b0;
    uart_clock_off = 1'b0;
    err_total = 0;
    n_tests = 0;
    irq_cnt = 0;
    irq_base = 0;
    cyc = 0;
    base = bv(urx_pkg::CT_RX_EN) | bv(urx_pkg::CT_RX_INT) | bv(urx_pkg::CT_UART_INT)
         | bv(urx_pkg::CT_GLOBAL_INT);
    idl = bv(urx_pkg::ST_RX_IDLE);
    av = bv(urx_pkg::ST_RX_AVAIL);
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rc("status", urx_pkg::ADDR_STATUS, idl);
    rc("control", urx_pkg::ADDR_CTRL, 32'h0);
    rc("divisor", urx_pkg::ADDR_BAUD, 32'h1);
    rc("unmapped", 4'h1, 32'h0);
    bus(1'b1, urx_pkg::ADDR_BAUD, 32'h1);
    bus(1'b1, urx_pkg::ADDR_CTRL, base);
    irq_base = irq_cnt;
    tx(9'h05A, 7'h00);
    irq_chk(1);
    rc("status", urx_pkg::ADDR_STATUS, idl | av);
    rc("data", urx_pkg::ADDR_DATA, 32'h5A);
    // Overrun: the data read before any status access must not clear it
    tx(9'h011, 7'h00);
    tx(9'h0A5, 7'h00);
    tx(9'h022, 7'h00);
    irq_chk(3);
    rc("data", urx_pkg::ADDR_DATA, 32'h11);
    bus(1'b1, urx_pkg::ADDR_STATUS, 32'hFF);
    rc("status", urx_pkg::ADDR_STATUS, idl | av | bv(urx_pkg::ST_OVERRUN));
    rc("data", urx_pkg::ADDR_DATA, 32'hA5);
    rc("status", urx_pkg::ADDR_STATUS, idl);
    tx(9'h03C, F_NZ);
    irq_chk(1);
    rc("status", urx_pkg::ADDR_STATUS, idl | av | bv(urx_pkg::ST_NOISE));
    rc("data", urx_pkg::ADDR_DATA, 32'h3C);
    rc("status", urx_pkg::ADDR_STATUS, idl);
    bus(1'b1, urx_pkg::ADDR_CTRL, base | bv(urx_pkg::CT_TWO_STOP));
    tx(9'h00F, F_TWO | F_BADS);
    rc("status", urx_pkg::ADDR_STATUS, idl | av | bv(urx_pkg::ST_FRAMING));
    rc("data", urx_pkg::ADDR_DATA, 32'h0F);
    tx(9'h0F0, F_TWO);
    rc("status", urx_pkg::ADDR_STATUS, idl | av);
    rc("data", urx_pkg::ADDR_DATA, 32'hF0);
    bus(1'b1, urx_pkg::ADDR_CTRL, base | bv(urx_pkg::CT_PARITY_EN));
    tx(9'h033, F_PAR | F_BADP);
    rc("status", urx_pkg::ADDR_STATUS, idl | av | bv(urx_pkg::ST_PARITY));
    rc("data", urx_pkg::ADDR_DATA, 32'h33);
    bus(1'b1, urx_pkg::ADDR_CTRL, base | bv(urx_pkg::CT_PARITY_EN) | bv(urx_pkg::CT_PARITY_ODD));
    tx(9'h033, F_PAR | F_ODD);
    rc("status", urx_pkg::ADDR_STATUS, idl | av);
    rc("data", urx_pkg::ADDR_DATA, 32'h33);
    irq_chk(4);
    // Address mode with parity off, eight then nine bit words
    bus(1'b1, urx_pkg::ADDR_CTRL, base | bv(urx_pkg::CT_ADDR_DET));
    tx(9'h012, 7'h00);
    irq_chk(0);
    tx(9'h085, 7'h00);
    irq_chk(1);
    rc("data", urx_pkg::ADDR_DATA, 32'h12);
    rc("data", urx_pkg::ADDR_DATA, 32'h85);
    bus(1'b1, urx_pkg::ADDR_CTRL, base | bv(urx_pkg::CT_ADDR_DET) | bv(urx_pkg::CT_NINE_BIT));
    tx(9'h080, F_NINE);
    irq_chk(0);
    tx(9'h100, F_NINE);
    irq_chk(1);
    rc("data", urx_pkg::ADDR_DATA, 32'h80);
    rc("data", urx_pkg::ADDR_DATA, 32'h100);
    bus(1'b1, urx_pkg::ADDR_CTRL, base & ~bv(urx_pkg::CT_GLOBAL_INT));
    tx(9'h077, 7'h00);
    irq_chk(0);
    rc("data", urx_pkg::ADDR_DATA, 32'h77);
    bus(1'b1, urx_pkg::ADDR_CTRL, base | bv(urx_pkg::CT_TX_EMPTY_IE));
    tx_empty <= 1'b1;
    irq_chk(1);
    tx_idle <= 1'b1;
    irq_chk(0);
    rc("status", urx_pkg::ADDR_STATUS, idl | bv(urx_pkg::ST_TX_EMPTY) | bv(urx_pkg::ST_TX_IDLE));
    bus(1'b1, urx_pkg::ADDR_CTRL, base | bv(urx_pkg::CT_WAKE));
    uart_clock_off <= 1'b1;
    urx_line_model_inst.wake_edge();
    irq_chk(1);
    uart_clock_off <= 1'b0;
    close_out();
  end

endmodule

`default_nettype wire
